// ===== conv_pkg.sv
package conv_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses on the bus)
    // ------------------------------------------------------------
    localparam logic [7:0] addr_status_control = 8'h00;
    localparam logic [7:0] addr_result = 8'h04;
    localparam logic [7:0] addr_clock_divider = 8'h08;
    localparam logic [7:0] addr_irq_status = 8'h0C;
    localparam logic [7:0] addr_irq_mask = 8'h10;
    localparam logic [7:0] addr_stop_control = 8'h14;

    // ------------------------------------------------------------
    // Field layout of the status/control and clock divider registers
    // ------------------------------------------------------------
    localparam int unsigned done_bit = 7;
    localparam int unsigned irq_en_bit = 6;
    localparam int unsigned cont_bit = 5;
    localparam int unsigned chan_lsb = 0;
    localparam int unsigned chan_w = 5;
    localparam int unsigned div_lsb = 5;
    localparam int unsigned div_w = 3;

    // ------------------------------------------------------------
    // Channel codes and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] chan_in0 = 5'h00;
    localparam logic [4:0] chan_in1 = 5'h01;
    localparam logic [4:0] chan_in2 = 5'h02;
    localparam logic [4:0] chan_in3 = 5'h03;
    localparam logic [4:0] chan_reserved = 5'h1B;
    localparam logic [4:0] chan_supply = 5'h1D;
    localparam logic [4:0] chan_ground = 5'h1E;
    localparam logic [4:0] chan_power_off = 5'h1F;
    localparam logic [2:0] div_reset = 3'h0;

    // ------------------------------------------------------------
    // Conversion timing in converter clock cycles
    // ------------------------------------------------------------
    localparam logic [4:0] conv_cycles = 5'h10;
    localparam logic [4:0] conv_cycles_max = 5'h11;
    localparam logic [3:0] prescale_max = 4'hF;

    // Status bits of the interrupt registers
    localparam int unsigned ev_done = 0;
    localparam int unsigned ev_abort = 1;
    localparam int unsigned ev_w = 2;

    typedef enum logic [1:0] {st_idle, st_wait_edge, st_convert} conv_state_t;
endpackage

// ===== conv_tick_if.sv
`timescale 1ns/1ps
interface conv_tick_if;
    logic [2:0] prescale_sel;
    logic restart;
    logic tick;
    modport gen (input prescale_sel, input restart, output tick);
    modport use_side (output prescale_sel, output restart, input tick);
endinterface

// ===== conv_clock_gen.sv
`timescale 1ns/1ps
module conv_clock_gen
    import conv_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Tick channel
    conv_tick_if.gen tk
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [3:0] limit;
    logic tick_q;

    // Division ratio from the prescale code; top bit set gives 16
    function automatic logic [3:0] div_limit(input logic [2:0] sel);
        case (sel)
            3'h0: div_limit = 4'h0;
            3'h1: div_limit = 4'h1;
            3'h2: div_limit = 4'h3;
            3'h3: div_limit = 4'h7;
            default: div_limit = prescale_max;
        endcase
    endfunction

    assign limit = div_limit(tk.prescale_sel);
    assign cnt_d = (tk.restart || cnt_q >= limit) ? 4'h0 : cnt_q + 4'h1;
    assign tk.tick = tick_q;

    // Divider counter; tick marks each converter clock rising edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= !tk.restart && (cnt_q >= limit);
        end
    end
endmodule

// ===== conv_control.sv
`timescale 1ns/1ps
// Overview of operation
// - Done flag set per conversion, cleared by result read
// - Interrupt mode: done flag never set, reads zero
// - Interrupt request at end, dropped by read/write
// - Continuous bit repeats conversions, else exactly one
// - Codes zero to three pick input pins
// - All ones powers converter off; reset value
// - Internal supply and ground reference codes
// - Eight-bit result register loaded each conversion
// - Three-bit prescaler divides by 1 to 16
// - Conversion lasts at most 17 converter cycles
// - Sixteen cycles, start after status/control write
// - Continuous results overwrite unread previous results
// - Stop aborts conversion; continuous mode resumes after stop exit unless the channel code is all ones
module conv_control
    import conv_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter core
    input wire logic [7:0] sample_value,
    output logic [3:0] pin_select,
    output logic supply_ref_sel,
    output logic ground_ref_sel,
    output logic core_power_on,
    output logic sample_hold,
    // Low-power control
    input wire logic stop_mode,
    // Interrupts
    output logic conv_irq,
    output logic irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic done_q;
    logic irq_en_q;
    logic cont_q;
    logic [4:0] chan_q;
    logic [2:0] div_q;
    logic [7:0] result_q;
    logic conv_irq_q;
    logic [ev_w-1:0] ev_stat_q;
    logic [ev_w-1:0] ev_mask_q;
    logic sw_stop_q;
    logic [4:0] cycle_q;
    logic [4:0] cycle_d;
    conv_state_t state_q;
    conv_state_t state_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [3:0] pin_q;
    logic sup_q;
    logic gnd_q;
    logic pwr_q;
    logic hold_q;
    logic irq_q;

    conv_tick_if tk();

    conv_clock_gen u_clk (
        .mclk(mclk),
        .rst(rst),
        .tk(tk)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire setup = psel && !penable;
    wire access = psel && penable && pready_q;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire hit_sc = paddr == addr_status_control;
    wire hit_res = paddr == addr_result;
    wire hit_div = paddr == addr_clock_divider;
    wire hit_ist = paddr == addr_irq_status;
    wire hit_msk = paddr == addr_irq_mask;
    wire hit_stp = paddr == addr_stop_control;
    wire mapped = hit_sc | hit_res | hit_div | hit_ist | hit_msk | hit_stp;
    wire sc_write = wr && hit_sc;
    wire res_read = rd && hit_res;
    wire ist_read = rd && hit_ist;
    wire stopped = stop_mode || sw_stop_q;
    wire powered = chan_q != chan_power_off;

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    wire last_cycle = tk.tick && (cycle_q == conv_cycles - 5'h01);
    wire conv_end = (state_q == st_convert) && last_cycle && !stopped && !sc_write;
    wire abort_ev = (state_q != st_idle) && stopped;

    // Next state of the sequencer
    always_comb begin
        state_d = state_q;
        cycle_d = cycle_q;
        case (state_q)
            st_idle: begin
                if (sc_write && !stopped) begin
                    state_d = st_wait_edge;
                end
            end
            st_wait_edge: begin
                if (stopped) begin
                    state_d = st_idle;
                end else if (tk.tick) begin
                    state_d = st_convert;
                    cycle_d = 5'h00;
                end
            end
            st_convert: begin
                if (stopped) begin
                    state_d = st_idle;
                end else if (sc_write) begin
                    state_d = st_wait_edge;
                end else if (tk.tick) begin
                    cycle_d = cycle_q + 5'h01;
                    if (last_cycle) begin
                        cycle_d = 5'h00;
                        state_d = cont_q ? st_convert : st_idle;
                    end
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    // Prescale select and divider restart
    assign tk.prescale_sel = div_q;
    assign tk.restart = (state_q == st_idle) || stopped;

    // Resume point after stop: restart continuous conversions on exit unless the channel code is power-off
    logic resume_q;
    wire resume = resume_q && !stopped && cont_q && powered;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= st_idle;
            cycle_q <= 5'h00;
            resume_q <= 1'b0;
        end else begin
            state_q <= resume ? st_wait_edge : state_d;
            cycle_q <= cycle_d;
            resume_q <= stopped ? (resume_q || abort_ev) : 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control, result and flag registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_en_q <= 1'b0;
            cont_q <= 1'b0;
            chan_q <= chan_power_off;
            div_q <= div_reset;
            sw_stop_q <= 1'b0;
            ev_mask_q <= '0;
        end else if (wr) begin
            if (hit_sc) begin
                irq_en_q <= pwdata[irq_en_bit];
                cont_q <= pwdata[cont_bit];
                chan_q <= pwdata[chan_lsb +: chan_w];
            end
            if (hit_div) begin
                div_q <= pwdata[div_lsb +: div_w];
            end
            if (hit_msk) begin
                ev_mask_q <= pwdata[ev_w-1:0];
            end
            if (hit_stp) begin
                sw_stop_q <= pwdata[0];
            end
        end
    end

    // Result and completion indications; a set beats a clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            result_q <= 8'h00;
            done_q <= 1'b0;
            conv_irq_q <= 1'b0;
            ev_stat_q <= '0;
        end else begin
            if (conv_end) begin
                result_q <= sample_value;
            end
            if (conv_end && !irq_en_q) begin
                done_q <= 1'b1;
            end else if (res_read || irq_en_q) begin
                done_q <= 1'b0;
            end
            if (conv_end && irq_en_q) begin
                conv_irq_q <= 1'b1;
            end else if (res_read || sc_write || !irq_en_q) begin
                conv_irq_q <= 1'b0;
            end
            ev_stat_q[ev_done] <= conv_end || (ev_stat_q[ev_done] && !ist_read);
            ev_stat_q[ev_abort] <= abort_ev || (ev_stat_q[ev_abort] && !ist_read);
        end
    end

    // ------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------
    wire [7:0] sc_view = {done_q && !irq_en_q, irq_en_q, cont_q, chan_q};
    wire [31:0] rd_mux = hit_sc ? {24'h000000, sc_view} :
                         hit_res ? {24'h000000, result_q} :
                         hit_div ? {24'h000000, div_q, 5'h00} :
                         hit_ist ? {30'h00000000, ev_stat_q} :
                         hit_msk ? {30'h00000000, ev_mask_q} :
                         hit_stp ? {31'h00000000, sw_stop_q} : 32'h00000000;

    // No wait states: pready rises in the first access cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            prdata_q <= (setup && !pwrite) ? rd_mux : prdata_q;
            pslverr_q <= setup && !mapped;
        end
    end

    // ------------------------------------------------------------
    // Core controls and interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_q <= 4'h0;
            sup_q <= 1'b0;
            gnd_q <= 1'b0;
            pwr_q <= 1'b0;
            hold_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            pin_q[0] <= chan_q == chan_in0;
            pin_q[1] <= chan_q == chan_in1;
            pin_q[2] <= chan_q == chan_in2;
            pin_q[3] <= chan_q == chan_in3;
            sup_q <= chan_q == chan_supply;
            gnd_q <= chan_q == chan_ground;
            pwr_q <= powered && !stopped;
            hold_q <= state_d == st_convert;
            irq_q <= |(ev_stat_q & ev_mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_select = pin_q;
    assign supply_ref_sel = sup_q;
    assign ground_ref_sel = gnd_q;
    assign core_power_on = pwr_q;
    assign sample_hold = hold_q;
    assign conv_irq = conv_irq_q;
    assign irq = irq_q;
endmodule

// ===== conv_checker.sv
`timescale 1ns/1ps
module conv_checker
    import conv_pkg::*;
(
    // Clock and reset
    input logic mclk,
    input logic rst,
    // Bus
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // Converter side
    input logic [7:0] sample_value,
    input logic [3:0] pin_select,
    input logic supply_ref_sel,
    input logic ground_ref_sel,
    input logic core_power_on,
    input logic sample_hold,
    input logic stop_mode,
    input logic conv_irq,
    input logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire acc_done = psel && penable && pready;
    wire sc_wr = acc_done && pwrite && paddr == addr_status_control;
    wire res_rd = acc_done && !pwrite && paddr == addr_result;
    wire sc_rd = acc_done && !pwrite && paddr == addr_status_control;
    logic [8:0] run_q;
    // Cycles of the conversion in progress
    always_ff @(posedge mclk) begin
        if (rst || !sample_hold) run_q <= 9'h000;
        else run_q <= run_q + 9'h001;
    end
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence irq_clear;
        conv_irq && (res_rd || sc_wr);
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    ready_after_setup_a: assert property (apb_setup |=> pready && penable) else $error("no answer after setup");
    ready_one_cycle_a: assert property (pready |=> !pready) else $error("ready held too long");
    refused_reads_zero_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("refused read not zero");
    done_masked_a: assert property (sc_rd && prdata[irq_en_bit] |-> !prdata[done_bit])
        else $error("done flag set in interrupt mode");
    power_off_a: assert property (sc_wr && pwdata[4:0] == chan_power_off |-> ##[1:3] !core_power_on)
        else $error("converter stays powered");
    reset_off_a: assert property ($fell(rst) |-> !core_power_on) else $error("powered after reset");
    pin_onehot_a: assert property ($onehot0(pin_select)) else $error("several pins selected");
    ref_exclusive_a: assert property (supply_ref_sel |-> !ground_ref_sel && pin_select == 4'h0)
        else $error("references overlap");
    conv_bound_a: assert property (sample_hold |-> run_q < 9'h110) else $error("conversion too long");
    irq_drop_a: assert property (irq_clear |-> ##[1:2] !conv_irq) else $error("interrupt not dropped");
    stop_idle_a: assert property (stop_mode [*3] |-> !sample_hold && !core_power_on)
        else $error("active during stop");
endmodule
bind conv_control conv_checker conv_checker_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_value(sample_value), .pin_select(pin_select), .supply_ref_sel(supply_ref_sel),
    .ground_ref_sel(ground_ref_sel), .core_power_on(core_power_on), .sample_hold(sample_hold),
    .stop_mode(stop_mode), .conv_irq(conv_irq), .irq(irq));

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    import conv_pkg::*;
    logic mclk, rst, psel, penable, pwrite, stop_mode, pready, pslverr, es;
    logic supply_ref_sel, ground_ref_sel, core_power_on, sample_hold, conv_irq, irq;
    logic [7:0] paddr, sample_value, c;
    logic [31:0] pwdata, prdata, rv, seed;
    logic [3:0] pin_select;
    int error_cnt = 0, checks = 0, exp_res, ratio, code;
    int codes[$] = '{29, 30, 31};
    conv_control conv_control_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_value(sample_value), .pin_select(pin_select), .supply_ref_sel(supply_ref_sel),
        .ground_ref_sel(ground_ref_sel), .core_power_on(core_power_on), .sample_hold(sample_hold),
        .stop_mode(stop_mode), .conv_irq(conv_irq), .irq(irq));
    // Clock
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // One bus transfer; read data lands in rv, refusal in es
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(0, 1, "bus wait expired");
        if (n >= 20) results();
        rv = prdata;
        es = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Wait for one conversion and measure it
    task automatic wait_conv(input int r);
        int n, len;
        n = 0;
        len = 0;
        while (sample_hold !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        while (sample_hold === 1'b1 && n < 800) begin
            @(posedge mclk);
            n++;
            len++;
        end
        if (len == 0 || n >= 800) chk(0, 1, "conversion wait expired");
        if (len == 0 || n >= 800) results();
        chk(len >= 16 * r && len <= 17 * r, 1, "conversion length");
    endtask
    task automatic new_sample();
        seed = lfsr(seed);
        sample_value <= seed[7:0];
        exp_res = seed[7:0];
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sample_value = 8'h00;
        stop_mode = 0;
        seed = 32'h000146E6;
        repeat (5) @(posedge mclk);
        rst <= 0;
        apb(0, addr_status_control, 0);
        chk(rv, 32'h1F, "status reset");
        chk(core_power_on, 0, "power after reset");
        apb(0, addr_clock_divider, 0);
        chk(rv, {div_reset, 5'h00}, "divider reset");
        apb(0, 8'h18, 0);
        chk({es, rv}, {1'b1, 32'h0}, "unmapped read");
        $display("test reset done");
        apb(1, addr_status_control, 0);
        repeat (8) @(posedge mclk);
        apb(1, addr_status_control, 0);
        repeat (40) @(posedge mclk);
        apb(0, addr_result, 0);
        for (int i = 0; i < 6; i++) begin
            code = (i < 5) ? i : 7;
            ratio = 1 << ((code > 3) ? 4 : code);
            apb(1, addr_clock_divider, code << div_lsb);
            apb(0, addr_clock_divider, 0);
            chk(rv, code << div_lsb, "divider readback");
            new_sample();
            apb(1, addr_status_control, i % 4);
            wait_conv(ratio);
            chk(pin_select, 1 << (i % 4), "pin select");
            repeat (17 * ratio) @(posedge mclk);
            chk(sample_hold, 0, "single conversion");
            apb(0, addr_status_control, 0);
            chk(rv, 32'h80 | (i % 4), "done flag set");
            apb(0, addr_result, 0);
            chk(rv, exp_res, "result");
            apb(0, addr_status_control, 0);
            chk(rv, i % 4, "done flag cleared");
        end
        $display("test single done");
        apb(1, addr_clock_divider, 0);
        apb(1, addr_irq_mask, 0);
        new_sample();
        apb(1, addr_status_control, 32'h42);
        wait_conv(1);
        repeat (2) @(posedge mclk);
        chk({conv_irq, irq}, 2'b10, "interrupt raised, masked");
        apb(0, addr_status_control, 0);
        chk(rv, 32'h42, "done reads zero");
        apb(1, addr_irq_mask, 1 << ev_done);
        repeat (2) @(posedge mclk);
        chk(irq, 1, "unmasked interrupt");
        apb(0, addr_result, 0);
        chk(rv, exp_res, "result irq mode");
        repeat (2) @(posedge mclk);
        chk(conv_irq, 0, "dropped by read");
        apb(0, addr_irq_status, 0);
        chk(rv[0], 1, "done event");
        repeat (2) @(posedge mclk);
        chk(irq, 0, "cleared by read");
        apb(1, addr_status_control, 32'h41);
        wait_conv(1);
        repeat (2) @(posedge mclk);
        apb(1, addr_status_control, 32'h1F);
        repeat (2) @(posedge mclk);
        chk(conv_irq, 0, "dropped by write");
        $display("test interrupt done");
        apb(1, addr_status_control, 32'h23);
        new_sample();
        repeat (40) @(posedge mclk);
        new_sample();
        repeat (40) @(posedge mclk);
        chk(sample_hold, 1, "continuous running");
        apb(0, addr_result, 0);
        chk(rv, exp_res, "overwritten result");
        stop_mode <= 1;
        repeat (4) @(posedge mclk);
        chk({sample_hold, core_power_on}, 2'b00, "stopped");
        stop_mode <= 0;
        repeat (40) @(posedge mclk);
        chk(sample_hold, 1, "resumed after stop");
        $display("test continuous done");
        apb(1, addr_status_control, 32'h03);
        foreach (codes[k]) begin
            c = codes[k];
            apb(1, addr_status_control, c);
            repeat (3) @(posedge mclk);
            chk({supply_ref_sel, ground_ref_sel}, {c == chan_supply, c == chan_ground}, "reference");
            chk(core_power_on, c != chan_power_off, "power state");
        end
        $display("test channel codes done");
        results();
    end
endmodule
